//--- logic/aih_pkg.sv
/*
  Constants for the adapter initialization handshake: frame fields, command
  codes, result codes, inquiry data layout, register offsets and states.
  Assumes a byte-wide frame link and an APB register bus at 32-bit data.
*/
package aih_pkg;
  // ==========================================================================
  // Frame fields
  localparam logic [7:0] AIH_START_BYTE = 8'h02;
  localparam logic [15:0] AIH_FRAME_TYPE = 16'h0002;
  localparam logic [7:0] AIH_CMD_INQ_REQ = 8'h00;
  localparam logic [7:0] AIH_CMD_DONE = 8'h01;
  localparam logic [7:0] AIH_CMD_START = 8'h02;
  localparam logic [7:0] AIH_CMD_OBJ_REQ = 8'h03;
  localparam logic [7:0] AIH_CMD_INQ_RSP = 8'h80;
  localparam logic [7:0] AIH_CMD_DONE_ACK = 8'h81;
  localparam logic [7:0] AIH_CMD_START_ACK = 8'h82;
  localparam logic [15:0] AIH_LEN_RESULT = 16'h0002;
  localparam logic [15:0] AIH_RES_OK = 16'h0000;
  localparam logic [15:0] AIH_RES_BAD = 16'h0011;
  localparam logic [15:0] AIH_RES_OTHER = 16'hffff;
  localparam int AIH_REQ_BYTES = 10;
  localparam int AIH_RSP_BYTES = 10;
  // ==========================================================================
  // Inquiry data layout (byte offsets inside the inquiry data)
  localparam int AIH_MAP_BYTES = 17;
  localparam int AIH_OFS_VALID = 0;
  localparam int AIH_OFS_SETMAP = 2 + AIH_MAP_BYTES;
  localparam int AIH_OFS_GETMAP = 2 + 3 * AIH_MAP_BYTES;
  localparam int AIH_OFS_ANNMAP = 2 + 4 * AIH_MAP_BYTES;
  localparam int AIH_OFS_ISETMAP = 2 + 5 * AIH_MAP_BYTES;
  localparam int AIH_OFS_IGETMAP = 2 + 6 * AIH_MAP_BYTES;
  localparam int AIH_OFS_IDENT = 2 + 9 * AIH_MAP_BYTES;
  localparam int AIH_ID_BYTES = 4 + 3 + 3 + 12 + 12 + 4;
  localparam int AIH_OFS_SIZEMAP = AIH_OFS_IDENT + AIH_ID_BYTES;
  localparam int AIH_SIZEMAP_MIN = 1;
  localparam int AIH_SIZEMAP_MAX = 128;
  localparam int AIH_INQ_MIN = AIH_OFS_SIZEMAP + AIH_SIZEMAP_MIN;
  localparam int AIH_INQ_MAX = AIH_OFS_SIZEMAP + AIH_SIZEMAP_MAX;
  localparam logic [15:0] AIH_VALID_IGNORE = 16'ha180;
  localparam int AIH_MAX_OBJ = 3;
  // ==========================================================================
  // APB register offsets
  localparam logic [7:0] AIH_REG_CTRL = 8'h00;
  localparam logic [7:0] AIH_REG_STATUS = 8'h04;
  localparam logic [7:0] AIH_REG_VALID = 8'h08;
  localparam logic [7:0] AIH_REG_LOOKUP = 8'h0c;
  localparam int AIH_CTRL_GO = 0;
  localparam int AIH_CTRL_BUILD_OK = 1;
  localparam int AIH_CTRL_NODE_OK = 2;
  localparam int AIH_CTRL_HAVE_OBJ = 3;
  // ==========================================================================
  // Sequence states
  typedef enum logic [3:0] {
    AIH_IDLE = 4'h0,
    AIH_RX_INQ = 4'h1,
    AIH_TX_DONE = 4'h2,
    AIH_WAIT_DONE = 4'h3,
    AIH_WAIT_BUILD = 4'h4,
    AIH_TX_START = 4'h5,
    AIH_WAIT_START = 4'h6,
    AIH_NORMAL = 4'h7,
    AIH_ERROR = 4'h8
  } aih_state_t;
endpackage

//--- logic/aih_map_mem.sv
/*
  Holds the set, get, internal set and internal get capability maps of every
  object, one bit per property code. Read data leave a register one cycle
  after the address. Assumes one writer, the inquiry parser.
*/
module aih_map_mem
  import aih_pkg::*;
#(
  parameter int DEPTH = 512
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // ==========================================================================
  // Storage
  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH < 4 * AIH_MAP_BYTES * AIH_MAX_OBJ) begin
      $error("aih_map_mem depth too small");
    end
  end

  // Write and registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // aih_map_mem

//--- logic/aih_core.sv
/*
  Adapter side of the initialization handshake: parses inquiry responses,
  keeps the capability maps, sends completion and startup notifications,
  checks their acceptance and answers property service lookups.
  Assumes byte streams with valid/ready, frame checks done outside, and an
  APB master for control and status.
*/
// Chosen here: the APB slave port and the address map.
module aih_core
  import aih_pkg::*;
#(
  parameter int MEM_DEPTH = 512
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received frame bytes, frame start marked, checks done upstream
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // Transmitted frame bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  // Sequence status
  output logic normal_op,
  output logic error_stop
);
  localparam int AW = $clog2(MEM_DEPTH);

  initial begin
    if (MEM_DEPTH < 4 * AIH_MAP_BYTES * AIH_MAX_OBJ) begin
      $error("aih_core memory depth too small");
    end
  end

  // Memory address of map byte: object, map index 0..3, byte
  function automatic logic [AW-1:0] map_addr(input logic [1:0] obj, input logic [1:0] map,
                                             input logic [4:0] idx);
    map_addr = AW'((32'(obj) * 4 + 32'(map)) * AIH_MAP_BYTES + 32'(idx));
  endfunction

  // Map index of a data offset, 4 when the byte holds no kept map
  function automatic logic [2:0] map_of(input logic [8:0] ofs);
    if (ofs >= 9'(AIH_OFS_SETMAP) && ofs < 9'(AIH_OFS_SETMAP + AIH_MAP_BYTES)) begin
      map_of = 3'd0;
    end else if (ofs >= 9'(AIH_OFS_GETMAP) && ofs < 9'(AIH_OFS_GETMAP + AIH_MAP_BYTES)) begin
      map_of = 3'd1;
    end else if (ofs >= 9'(AIH_OFS_ISETMAP) && ofs < 9'(AIH_OFS_ISETMAP + AIH_MAP_BYTES)) begin
      map_of = 3'd2;
    end else if (ofs >= 9'(AIH_OFS_IGETMAP) && ofs < 9'(AIH_OFS_IGETMAP + AIH_MAP_BYTES)) begin
      map_of = 3'd3;
    end else begin
      map_of = 3'd4;
    end
  endfunction

  // Byte of the outgoing notification frame
  function automatic logic [7:0] tx_frame(input logic [3:0] i, input logic [7:0] cmd,
                                          input logic [7:0] fn, input logic [15:0] res);
    case (i)
      4'd0: tx_frame = AIH_START_BYTE;
      4'd1: tx_frame = AIH_FRAME_TYPE[15:8];
      4'd2: tx_frame = AIH_FRAME_TYPE[7:0];
      4'd3: tx_frame = cmd;
      4'd4: tx_frame = fn;
      4'd5: tx_frame = AIH_LEN_RESULT[15:8];
      4'd6: tx_frame = AIH_LEN_RESULT[7:0];
      4'd7: tx_frame = res[15:8];
      4'd8: tx_frame = res[7:0];
      default: tx_frame = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // State
  typedef struct packed {
    aih_state_t st;
    logic [3:0] hdr;
    logic [7:0] cmd;
    logic [7:0] fn;
    logic [15:0] len;
    logic [15:0] res;
    logic [1:0] nobj;
    logic [1:0] got;
    logic [1:0] total;
    logic [1:0] cur;
    logic [3:0] osub;
    logic [8:0] dofs;
    logic [8:0] dlen;
    logic [15:0] valid;
    logic bad;
    logic [15:0] tx_res;
    logic [7:0] tx_cmd;
    logic [3:0] tx_idx;
    logic [7:0] tx_fn;
    logic build_ok;
    logic node_ok;
    logic have_obj;
    logic [31:0] rdata;
    logic [1:0] lk_obj;
    logic [7:0] lk_code;
    logic [1:0] lk_state;
    logic [1:0] lk_svc;
  } aih_core_t;

  aih_core_t r;
  aih_core_t next_r;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [AW-1:0] mem_ra;
  logic [7:0] mem_rd;
  logic [2:0] cur_map;
  logic [15:0] rsp_res;

  aih_map_mem #(.DEPTH(MEM_DEPTH)) u_maps (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(rx_byte),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  // Handshakes and flags
  assign rx_ready = 1'b1;
  assign pready = 1'b1;
  assign tx_valid = (r.st == AIH_TX_DONE) || (r.st == AIH_TX_START);
  assign tx_last = r.tx_idx == 4'(AIH_REQ_BYTES - 1);
  assign prdata = r.rdata;
  assign normal_op = r.st == AIH_NORMAL;
  assign error_stop = r.st == AIH_ERROR;
  assign cur_map = map_of(r.dofs);
  assign rsp_res = {r.res[15:8], rx_byte};

  // Map bytes land in memory as they stream past; padding is never stored
  always_comb begin
    mem_we = 1'b0;
    mem_wa = map_addr(r.cur, cur_map[1:0], 5'(r.dofs - 9'(AIH_OFS_SETMAP)));
    if (r.st == AIH_RX_INQ && rx_valid && !rx_first && r.hdr == 4'd10
        && r.osub == 4'd6 && !cur_map[2]) begin
      mem_we = 1'b1;
      case (cur_map[1:0])
        2'd0: mem_wa = map_addr(r.cur, 2'd0, 5'(r.dofs - 9'(AIH_OFS_SETMAP)));
        2'd1: mem_wa = map_addr(r.cur, 2'd1, 5'(r.dofs - 9'(AIH_OFS_GETMAP)));
        2'd2: mem_wa = map_addr(r.cur, 2'd2, 5'(r.dofs - 9'(AIH_OFS_ISETMAP)));
        default: mem_wa = map_addr(r.cur, 2'd3, 5'(r.dofs - 9'(AIH_OFS_IGETMAP)));
      endcase
    end
    mem_ra = map_addr(r.lk_obj, {1'b1, r.lk_svc[0]}, 5'(r.lk_code[7:3]));
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    // APB write and read
    if (psel && penable && pwrite) begin
      case (paddr)
        AIH_REG_CTRL: begin
          next_r.build_ok = pwdata[AIH_CTRL_BUILD_OK];
          next_r.node_ok = pwdata[AIH_CTRL_NODE_OK];
          next_r.have_obj = pwdata[AIH_CTRL_HAVE_OBJ];
          if (pwdata[AIH_CTRL_GO] && (r.st == AIH_IDLE || r.st == AIH_ERROR)) begin
            next_r.st = AIH_RX_INQ;
            next_r.got = 2'd0;
            next_r.bad = 1'b0;
            next_r.hdr = 4'd0;
          end
        end
        AIH_REG_LOOKUP: begin
          next_r.lk_obj = pwdata[9:8];
          next_r.lk_code = pwdata[7:0];
          next_r.lk_svc = {1'b0, pwdata[16]};
          next_r.lk_state = 2'd1;
        end
        default: begin
        end
      endcase
    end
    // Lookup: wait for registered memory read, then pick the code's bit
    if (r.lk_state == 2'd1) begin
      next_r.lk_state = 2'd2;
    end else if (r.lk_state == 2'd2) begin
      next_r.lk_state = 2'd3;
      next_r.lk_svc[1] = mem_rd[3'd7 - r.lk_code[2:0]];
    end
    case (paddr)
      AIH_REG_CTRL: next_r.rdata = {28'h0000000, r.have_obj, r.node_ok, r.build_ok, 1'b0};
      AIH_REG_STATUS: next_r.rdata = {16'h0000, r.bad, 1'b0, r.total, 2'b00, r.got,
                                      4'h0, r.st};
      AIH_REG_VALID: next_r.rdata = {16'h0000, r.valid & ~AIH_VALID_IGNORE};
      AIH_REG_LOOKUP: next_r.rdata = {28'h0000000, r.lk_state == 2'd3, r.lk_svc[1],
                                      r.lk_svc[0], 1'b0};
      default: next_r.rdata = 32'h00000000;
    endcase
    // Frame reception
    if (rx_valid) begin
      if (rx_first) begin
        next_r.hdr = 4'd1;
      end else if (r.hdr != 4'd0 && r.hdr < 4'd10) begin
        next_r.hdr = r.hdr + 4'd1;
        case (r.hdr)
          4'd2: next_r.cmd = 8'h00;
          4'd3: next_r.cmd = rx_byte;
          4'd4: next_r.fn = rx_byte;
          4'd5: next_r.len[15:8] = rx_byte;
          4'd6: next_r.len[7:0] = rx_byte;
          4'd7: next_r.res[15:8] = rx_byte;
          4'd8: next_r.res[7:0] = rx_byte;
          default: begin
          end
        endcase
        // Acceptance is judged on its last result byte
        // The sent number was stepped on the last byte, so match one below
        if (r.hdr == 4'd8 && r.st == AIH_WAIT_DONE && r.cmd == AIH_CMD_DONE_ACK) begin
          if (r.fn == 8'(r.tx_fn - 8'd1) || r.fn == 8'h00) begin
            next_r.st = (rsp_res == AIH_RES_OK && !r.bad) ? AIH_WAIT_BUILD : AIH_ERROR;
          end
        end
        if (r.hdr == 4'd8 && r.st == AIH_WAIT_START && r.cmd == AIH_CMD_START_ACK) begin
          if (r.fn == 8'(r.tx_fn - 8'd1) || r.fn == 8'h00) begin
            next_r.st = (rsp_res == AIH_RES_OK && r.tx_res == AIH_RES_OK)
                        ? AIH_NORMAL : AIH_ERROR;
          end
        end
        if (r.hdr == 4'd9 && r.st == AIH_RX_INQ && r.cmd == AIH_CMD_INQ_RSP) begin
          next_r.nobj = rx_byte[1:0];
          next_r.osub = 4'd0;
          if (r.res != AIH_RES_OK || rx_byte == 8'h00
              || rx_byte > 8'(AIH_MAX_OBJ)) begin
            next_r.bad = 1'b1;
            next_r.hdr = 4'd0;
            next_r.st = AIH_TX_DONE;
          end
        end
      end else if (r.hdr == 4'd10 && r.st == AIH_RX_INQ && r.nobj != 2'd0) begin
        // Object data: id byte, code 3, length 2, inquiry data
        case (r.osub)
          4'd0: begin
            next_r.total = rx_byte[5:4];
            next_r.cur = 2'(rx_byte[1:0] - 2'd1);
            if (rx_byte[3:0] == 4'h0 || rx_byte[3:0] > rx_byte[7:4]
                || rx_byte[7:4] > 4'(AIH_MAX_OBJ)) begin
              next_r.bad = 1'b1;
            end
            next_r.osub = 4'd1;
          end
          4'd4: begin
            next_r.dlen[8] = rx_byte[0];
            next_r.osub = 4'd5;
          end
          4'd5: begin
            next_r.dlen[7:0] = rx_byte;
            next_r.dofs = 9'd0;
            if ({r.dlen[8], rx_byte} < 9'(AIH_INQ_MIN)
                || {r.dlen[8], rx_byte} > 9'(AIH_INQ_MAX)) begin
              next_r.bad = 1'b1;
            end
            next_r.osub = 4'd6;
          end
          4'd6: begin
            if (r.dofs == 9'(AIH_OFS_VALID)) begin
              next_r.valid[15:8] = rx_byte;
            end
            if (r.dofs == 9'(AIH_OFS_VALID + 1)) begin
              next_r.valid[7:0] = rx_byte;
            end
            next_r.dofs = r.dofs + 9'd1;
            if (r.dofs + 9'd1 == r.dlen) begin
              next_r.osub = 4'd0;
              next_r.nobj = r.nobj - 2'd1;
              next_r.got = r.got + 2'd1;
              // All objects in: notify completion
              if (r.nobj == 2'd1 && (r.got + 2'd1 >= r.total)) begin
                next_r.st = AIH_TX_DONE;
              end
            end
          end
          default: next_r.osub = r.osub + 4'd1;
        endcase
      end
    end
    // Wait for node_ok before announcing startup; build_ok and have_obj pick its result
    if (r.st == AIH_WAIT_BUILD && r.node_ok) begin
      next_r.st = AIH_TX_START;
      next_r.tx_res = (r.build_ok && r.have_obj) ? AIH_RES_OK : AIH_RES_BAD;
    end
    if (r.st == AIH_TX_DONE && r.tx_idx == 4'd0) begin
      next_r.tx_cmd = AIH_CMD_DONE;
      next_r.tx_res = r.bad ? AIH_RES_BAD : AIH_RES_OK;
    end
    if (r.st == AIH_TX_START && r.tx_idx == 4'd0) begin
      next_r.tx_cmd = AIH_CMD_START;
    end
    // Notification transmit
    if (tx_valid && tx_ready) begin
      next_r.tx_idx = r.tx_idx + 4'd1;
      if (tx_last) begin
        next_r.tx_idx = 4'd0;
        next_r.tx_fn = r.tx_fn + 8'd1;
        next_r.st = (r.st == AIH_TX_DONE) ? AIH_WAIT_DONE : AIH_WAIT_START;
      end
    end
  end

  // Outgoing byte from a register-free function of held state
  always_comb begin
    tx_byte = tx_frame(r.tx_idx, (r.st == AIH_TX_DONE) ? AIH_CMD_DONE : AIH_CMD_START,
                       r.tx_fn, (r.st == AIH_TX_DONE) ? (r.bad ? AIH_RES_BAD : AIH_RES_OK)
                       : r.tx_res);
    if (r.tx_idx == 4'd9) begin
      tx_byte = 8'h00;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.tx_fn <= 8'h01;
    end else begin
      r <= next_r;
    end
  end

  assign pslverr = 1'b0;

  // ==========================================================================
  // Checks
  invalid_goes_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == AIH_WAIT_DONE && r.bad) |=> (r.st == AIH_WAIT_DONE || r.st == AIH_ERROR)
    ) else $error("invalid completion did not stop");
  normal_needs_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(normal_op) |-> $past(r.tx_res) == AIH_RES_OK
    ) else $error("normal operation after failed startup");
  start_needs_node_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == AIH_TX_START && $past(r.st) == AIH_WAIT_BUILD) |-> $past(r.node_ok)
    ) else $error("startup sent before node profile");
  tx_frame_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_valid && r.tx_idx == 4'd0) |-> tx_byte == AIH_START_BYTE
    ) else $error("frame start byte wrong");
  tx_cmd_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_valid && r.tx_idx == 4'd3) |-> tx_byte == ((r.st == AIH_TX_DONE) ? 8'h01 : 8'h02)
    ) else $error("command code wrong");
  valid_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && paddr == AIH_REG_VALID) |=> (prdata[15] == 1'b0 && prdata[13] == 1'b0
                                           && prdata[8] == 1'b0 && prdata[7] == 1'b0)
    ) else $error("ignored validity bits visible");
  done_after_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == AIH_TX_DONE && tx_ready && tx_last) |=> r.st == AIH_WAIT_DONE
    ) else $error("no wait for completion acceptance");
  fail_start_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.st == AIH_WAIT_START && r.tx_res == AIH_RES_BAD) |-> !normal_op ##1 !normal_op
    ) else $error("failed startup reached normal");
endmodule // aih_core

//--- verif/aih_equip_model.sv
/*
  Equipment side: takes notification frames and answers each one with an
  acceptance frame. It also sends the inquiry bytes that the bench queues.
  Assumes the adapter's pclk domain.
*/
module aih_equip_model
  import aih_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic slow,
  input wire logic [15:0] ack_res,
  // Link
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  output logic tx_ready,
  output logic rx_valid,
  output logic rx_first,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  logic [7:0] frm[10];
  int n_frm = 0;
  int k = 0;
  // =========================================================
  // Queue one frame header, start byte marked
  task automatic hdr(input logic [7:0] c, input logic [7:0] f, input logic [15:0] r);
    logic [71:0] v;
    v = {AIH_START_BYTE, AIH_FRAME_TYPE, c, f, AIH_LEN_RESULT, r};
    for (int i = 0; i < 9; i++) q.push_back({i == 0, v[71-8*i -: 8]});
  endtask
  // =========================================================
  // Capture, reply, send; an idle data line flips every cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      rx_byte <= 8'h00;
      k = 0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        frm[k] = tx_byte;
        k = (k + 1) % 10;
        if (tx_last) begin
          n_frm <= n_frm + 1;
          k = 0;
          hdr(frm[3] | 8'h80, frm[4], ack_res);
          q.push_back(9'h000);
        end
      end
      if (q.size() > 0 && !(slow && rx_valid)) begin
        {rx_first, rx_byte} <= q.pop_front();
        rx_valid <= 1'b1;
      end else begin
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end
    end
  end
endmodule // aih_equip_model

//--- verif/adapter_init_handshake_bench.sv
/*
  Self-checking bench of the adapter handshake core.
  Assumes the equipment model in aih_equip_model.
*/
module adapter_init_handshake_bench;
  import aih_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr, rx_byte, tx_byte, exp_fn;
  logic [31:0] pwdata, prdata, r, seed;
  logic rx_valid, rx_first, rx_ready, tx_valid, tx_last, tx_ready, normal_op, error_stop;
  logic [15:0] ack_res, bm;
  int n_mismatch = 0;
  int tests_run = 0;
  int nf = 0;
  int cyc = 0;
  aih_core #(.MEM_DEPTH(512)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_first(rx_first),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_last(tx_last), .tx_ready(tx_ready), .normal_op(normal_op), .error_stop(error_stop));
  aih_equip_model u_eq (.pclk(pclk), .presetn(presetn), .slow(slow), .ack_res(ack_res),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte));
  // =========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] nbyte(int i, logic [7:0] c, logic [15:0] res);
    logic [79:0] v;
    v = {AIH_START_BYTE, AIH_FRAME_TYPE, c, exp_fn, AIH_LEN_RESULT, res, 8'h00};
    return v[79-8*i -: 8];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic inq(input logic [3:0] tot, input logic [3:0] id0, input int n,
                     input logic [15:0] res);
    logic [7:0] b;
    if (res == 16'h0) bm = {rnd(), rnd()}; // Bitmap only lands from good data
    u_eq.hdr(AIH_CMD_INQ_RSP, 8'h01, res);
    u_eq.q.push_back({1'b0, 8'(n)});
    for (int o = 0; o < n; o++) begin
      u_eq.q.push_back({1'b0, tot, id0 + 4'(o)});
      for (int i = 0; i < 205; i++) begin
        b = rnd();
        if (i == 3) b = 8'h00;
        if (i == 4) b = 8'hc8;
        if (i == 5) b = bm[15:8];
        if (i == 6) b = bm[7:0];
        if (i == 92) b = 8'h80;
        if (i == 109) b = 8'h40;
        u_eq.q.push_back({1'b0, b});
      end
    end
  endtask
  task automatic note(input logic [7:0] c, input logic [15:0] res);
    nf++;
    while (u_eq.n_frm < nf) @(posedge pclk);
    for (int i = 0; i < 10; i++) chk(32'(u_eq.frm[i]), 32'(nbyte(i, c, res)));
    exp_fn++;
  endtask
  // One whole sequence from a start command
  task automatic run(input logic [3:0] ctl, input int n, input logic [15:0] ires,
                     input logic [15:0] sack);
    logic ok;
    ack_res <= 16'h0000;
    apb(1'b1, AIH_REG_CTRL, {28'h0, ctl});
    inq(4'(n), 4'h1, 1, ires);
    if (n > 1) inq(4'(n), 4'h2, n - 1, ires);
    note(AIH_CMD_DONE, ires == 16'h0 ? AIH_RES_OK : AIH_RES_BAD);
    apb(1'b0, AIH_REG_VALID, 32'h0);
    chk(r, {16'h0, bm & 16'h5e7f});
    if (ires == 16'h0) begin
      ack_res <= sack;
      note(AIH_CMD_START, (ctl[3] && ctl[1]) ? AIH_RES_OK : AIH_RES_BAD);
    end
    ok = ires == 16'h0 && ctl[3] && ctl[1] && sack == 16'h0;
    for (int i = 0; i < 300 && (normal_op | error_stop) !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, normal_op}, {31'h0, ok});
    chk({31'h0, error_stop}, {31'h0, !ok});
    apb(1'b0, AIH_REG_STATUS, 32'h0);
    chk({28'h0, r[3:0]}, ok ? 32'h7 : 32'h8);
    // Service lookups on object 1: internal set code 00, internal get code 00, internal get code 01
    if (ires == 16'h0) begin
      for (int j = 0; j < 3; j++) begin
        apb(1'b1, AIH_REG_LOOKUP, {15'h0, j != 0, 15'h0, j == 2});
        repeat (2) @(posedge pclk);
        apb(1'b0, AIH_REG_LOOKUP, 32'h0);
        chk({28'h0, r[3:0]}, j == 0 ? 32'hc : (j == 1 ? 32'ha : 32'he));
      end
    end
    $display("test done: %0d objects", n);
  endtask
  task automatic print_verdict();
    $display("counts: compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // =========================================================
  // Clock, timeout, main sequence
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, slow} = 5'h0;
    {paddr, pwdata, ack_res, seed, exp_fn} = {8'h0, 32'h0, 16'h0, 32'd54, 8'h01};
    bm = 16'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AIH_REG_STATUS, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, AIH_REG_CTRL, 32'he);
    apb(1'b1, 8'h10, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, AIH_REG_CTRL, 32'h0);
    chk(r, 32'he);
    chk({30'h0, rx_ready, pslverr}, 32'h2);
    $display("test done: registers");
    run(4'hf, 1, AIH_RES_OTHER, 16'h0);
    slow <= 1'b1;
    run(4'hf, 3, AIH_RES_OK, AIH_RES_OTHER);
    run(4'h7, 2, AIH_RES_OK, AIH_RES_OK);
    slow <= rnd() > 8'h7f;
    run(4'hf, 1 + int'(rnd() % 3), AIH_RES_OK, AIH_RES_OK);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AIH_REG_STATUS, 32'h0);
    chk(r, 32'h0);
    $display("test done: reset");
    print_verdict();
  end
endmodule // adapter_init_handshake_bench
